/* hdl/lsc_sync_ctrl.sv */
// Purpose: multiframe clock alignment, sysref monitoring and link latency control
// Assumes: sys_clk is the dac clock; sysref and data_start are synchronous to it
// Notes:   processing clock and sysref sampling use the divide-by-4 enable
`timescale 1ns/100ps
`default_nettype none
`include "lsc_defines.svh"

module lsc_sync_ctrl #(
	parameter int PCLKS_PER_MF = 16
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       sysref,
	input  wire logic       data_start,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	output logic            pclk_en,
	output logic            local_multiframe_clock,
	output logic            lane_read_start,
	output logic            link_enable,
	output logic            ref_phase_error_irq
);
	localparam int CW = $clog2(PCLKS_PER_MF);
	localparam int EW = CW + 2;

	initial begin
		if (PCLKS_PER_MF < 2 || PCLKS_PER_MF > 1024 || (1 << CW) != PCLKS_PER_MF)
			$error("lsc_sync_ctrl: PCLKS_PER_MF must be a power of two from 2 to 1024");
	end

	lsc_pkg::lsc_sync_state_e state;
	logic [1:0]    div_cnt;
	logic          sysref_d;
	logic          rise_pending;
	logic [1:0]    rise_phase;
	logic [CW-1:0] lmfc_cnt;
	logic [CW-1:0] ref_cnt;
	logic [5:0]    ref_phase_tolerance;
	logic [1:0]    alignment_mode_select;
	logic [2:0]    subclass;
	logic [7:0]    multiframe_delay_value;
	logic [3:0]    latency_variation_value;
	logic [7:0]    ref_pulse_counter;
	logic [7:0]    count_capture;
	logic [11:0]   last_error;
	logic [11:0]   alignment_status_capture;
	logic [11:0]   ref_sample_phase;
	logic [7:0]    latency_cnt;
	logic [7:0]    link_latency;
	logic          rbd_fire;

	logic          raw_rise;
	logic          align_ev;
	logic          do_align;
	logic [EW-1:0] err_pos;
	logic [EW-1:0] err_dist;
	logic          err_outside;
	logic [CW-1:0] delay_mod;
	logic          wr_status;
	logic          wr_count;
	logic          wr_mode;
	logic          wr_irq;

	assign wr_status = reg_wr && reg_addr == `LSC_OFF_STATUS_LOW;
	assign wr_count  = reg_wr && reg_addr == `LSC_OFF_PULSE_COUNT;
	assign wr_mode   = reg_wr && reg_addr == `LSC_OFF_MODE_CFG;
	assign wr_irq    = reg_wr && reg_addr == `LSC_OFF_IRQ_STATUS;

	// divide-by-4 enable, which is also the processing clock rate
	always_ff @(posedge sys_clk) begin
		if (sys_rst) div_cnt <= 2'h0;
		else         div_cnt <= div_cnt + 2'h1;
	end
	assign pclk_en = div_cnt == 2'(`LSC_DIV_RATIO - 1);

	// sysref edge is held until the next divided sample point
	assign raw_rise = sysref && !sysref_d;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sysref_d     <= 1'b0;
			rise_pending <= 1'b0;
			rise_phase   <= 2'h0;
		end else begin
			sysref_d <= sysref;
			if (raw_rise) rise_phase <= div_cnt;
			rise_pending <= (rise_pending || raw_rise) && !pclk_en;
		end
	end

	// free-running internal reference stands in for sysref in subclass 0
	always_ff @(posedge sys_clk) begin
		if (sys_rst)      ref_cnt <= '0;
		else if (pclk_en) ref_cnt <= ref_cnt + CW'(1);
	end

	always_comb begin
		if (subclass == `LSC_SUBCLASS_0)
			align_ev = pclk_en && ref_cnt == '0;
		else
			align_ev = pclk_en && (rise_pending || raw_rise);
	end

	// phase error in dac clocks, at div-4 granularity
	assign err_pos  = {lmfc_cnt, 2'b00};
	assign err_dist = (err_pos > EW'(PCLKS_PER_MF * 2)) ? EW'(PCLKS_PER_MF * 4) - err_pos : err_pos;
	assign err_outside = err_dist > EW'(ref_phase_tolerance & `LSC_WINDOW_MASK);

	assign do_align = align_ev && (state == lsc_pkg::ST_ARMED || state == lsc_pkg::ST_CONTINUOUS);

	// sync mode state machine
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= lsc_pkg::ST_MONITOR;
		end else if (wr_mode) begin
			case (reg_wdata[1:0])
				`LSC_MODE_ONE_SHOT:   state <= lsc_pkg::ST_ARMED;
				`LSC_MODE_CONTINUOUS: state <= lsc_pkg::ST_CONTINUOUS;
				default:              state <= lsc_pkg::ST_MONITOR;
			endcase
		end else begin
			case (state)
				lsc_pkg::ST_ARMED:      if (align_ev) state <= lsc_pkg::ST_MONITOR;
				lsc_pkg::ST_CONTINUOUS: state <= lsc_pkg::ST_CONTINUOUS;
				lsc_pkg::ST_MONITOR:    state <= lsc_pkg::ST_MONITOR;
				default:                state <= lsc_pkg::ST_MONITOR;
			endcase
		end
	end

	// sysref-aligned multiframe counter; edge lands on count zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			lmfc_cnt <= '0;
		else if (do_align)
			lmfc_cnt <= CW'(1);
		else if (pclk_en)
			lmfc_cnt <= lmfc_cnt + CW'(1);
	end

	// error snapshot, sampling phase and sticky jitter flag
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			last_error       <= 12'h000;
			ref_sample_phase <= 12'h000;
		end else if (align_ev) begin
			last_error       <= 12'(err_pos);
			ref_sample_phase <= 12'((12'h020 << (raw_rise ? div_cnt : rise_phase)) - 12'h010);
		end
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ref_phase_error_irq <= 1'b0;
		else if (align_ev && err_outside)
			ref_phase_error_irq <= 1'b1;
		else if (wr_irq && reg_wdata[0])
			ref_phase_error_irq <= 1'b0;
	end

	// pulse counter: increment beats a clearing write, leaving one
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ref_pulse_counter <= 8'h00;
		else if (wr_count)
			ref_pulse_counter <= (align_ev && subclass != `LSC_SUBCLASS_0) ? 8'h01 : 8'h00;
		else if (align_ev && subclass != `LSC_SUBCLASS_0 && ref_pulse_counter != 8'hff)
			ref_pulse_counter <= ref_pulse_counter + 8'h01;
	end

	// status capture for readback
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			alignment_status_capture <= 12'h000;
			count_capture            <= 8'h00;
		end else if (wr_status) begin
			alignment_status_capture <= last_error;
			count_capture            <= ref_pulse_counter;
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ref_phase_tolerance     <= `LSC_RST_WINDOW;
			alignment_mode_select   <= `LSC_RST_MODE;
			subclass                <= `LSC_RST_SUBCLASS;
			multiframe_delay_value  <= `LSC_RST_DELAY;
			latency_variation_value <= `LSC_RST_VARIATION;
			link_enable             <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`LSC_OFF_WINDOW_CFG:    ref_phase_tolerance <= reg_wdata[5:0];
				`LSC_OFF_MODE_CFG:      alignment_mode_select <= reg_wdata[1:0];
				`LSC_OFF_LINK_CTRL:     link_enable <= reg_wdata[0];
				`LSC_OFF_DELAY_CFG:     multiframe_delay_value <= reg_wdata;
				`LSC_OFF_VARIATION_CFG: begin
					// values above the buffer depth saturate
					if (reg_wdata > 8'(`LSC_RBD_MAX)) latency_variation_value <= `LSC_RBD_MAX;
					else                              latency_variation_value <= reg_wdata[3:0];
				end
				`LSC_OFF_SUBCLASS_CFG: begin
					// subclass 2 and above are refused, old value kept
					if (reg_wdata[7:`LSC_SUBCLASS_LSB] <= `LSC_SUBCLASS_1)
						subclass <= reg_wdata[7:`LSC_SUBCLASS_LSB];
				end
				default: ;
			endcase
		end
	end

	// local multiframe clock: delayed copy of the aligned counter
	assign delay_mod = CW'(multiframe_delay_value); // power-of-two period: truncation is the modulo
	assign local_multiframe_clock = pclk_en && lmfc_cnt == delay_mod;

	// dynamic latency from local boundary to first data
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			latency_cnt  <= 8'h00;
			link_latency <= 8'h00;
		end else begin
			if (local_multiframe_clock)
				latency_cnt <= 8'h00;
			else if (pclk_en && latency_cnt != 8'hff)
				latency_cnt <= latency_cnt + 8'h01;
			if (data_start && link_enable)
				link_latency <= latency_cnt;
		end
	end

	// one release shared by all lanes keeps them in one period
	lsc_rbd_delay #(
		.DW (4)
	) u_rbd (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.tick    (pclk_en),
		.start   (local_multiframe_clock),
		.delay   (latency_variation_value),
		.fire    (rbd_fire)
	);
	assign lane_read_start = rbd_fire && link_enable;

	// register read port, answer one cycle after reg_rd
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`LSC_OFF_STATUS_LOW:    reg_rdata <= alignment_status_capture[7:0];
				`LSC_OFF_STATUS_HIGH:   reg_rdata <= {4'h0, alignment_status_capture[11:8]};
				`LSC_OFF_PULSE_COUNT:   reg_rdata <= count_capture;
				`LSC_OFF_PHASE_LOW:     reg_rdata <= ref_sample_phase[7:0];
				`LSC_OFF_PHASE_HIGH:    reg_rdata <= {4'h0, ref_sample_phase[11:8]};
				`LSC_OFF_WINDOW_CFG:    reg_rdata <= {2'h0, ref_phase_tolerance};
				`LSC_OFF_MODE_CFG:      reg_rdata <= {6'h00, alignment_mode_select};
				`LSC_OFF_IRQ_STATUS:    reg_rdata <= {7'h00, ref_phase_error_irq};
				`LSC_OFF_LINK_CTRL:     reg_rdata <= {7'h00, link_enable};
				`LSC_OFF_LATENCY:       reg_rdata <= link_latency;
				`LSC_OFF_DELAY_CFG:     reg_rdata <= multiframe_delay_value;
				`LSC_OFF_VARIATION_CFG: reg_rdata <= {4'h0, latency_variation_value};
				`LSC_OFF_SUBCLASS_CFG:  reg_rdata <= {subclass, 5'h00};
				default:                reg_rdata <= 8'h00;
			endcase
		end
	end

	// checks
	property p_monitor_no_adjust;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == lsc_pkg::ST_MONITOR && !wr_mode && pclk_en) |=> lmfc_cnt == $past(lmfc_cnt) + CW'(1);
	endproperty
	a_monitor_no_adjust: assert property (p_monitor_no_adjust) else $error("monitor mode moved the counter");

	property p_snapshot;
		@(posedge sys_clk) disable iff (sys_rst)
		align_ev |=> last_error == 12'($past(err_pos));
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("error snapshot missing");

	property p_mode_decode;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_mode && reg_wdata[1:0] == `LSC_MODE_CONTINUOUS) |=> state == lsc_pkg::ST_CONTINUOUS;
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("continuous code not decoded");

	sequence s_armed_edge;
		state == lsc_pkg::ST_ARMED && align_ev && !wr_mode;
	endsequence
	sequence s_aligned_then_monitor;
		lmfc_cnt == CW'(1) && state == lsc_pkg::ST_MONITOR;
	endsequence
	property p_one_shot;
		@(posedge sys_clk) disable iff (sys_rst)
		s_armed_edge |=> s_aligned_then_monitor;
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("one-shot did not align and fall back");

	property p_count_clear;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_count && !align_ev) |=> ref_pulse_counter == 8'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

	property p_status_latch;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_status |=> count_capture == $past(ref_pulse_counter) && alignment_status_capture == $past(last_error);
	endproperty
	a_status_latch: assert property (p_status_latch) else $error("status not latched");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		(ref_phase_error_irq && !wr_irq) |=> ref_phase_error_irq;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("jitter flag dropped");

	property p_inside_window;
		@(posedge sys_clk) disable iff (sys_rst)
		(!ref_phase_error_irq && (!align_ev || !err_outside)) |=> !ref_phase_error_irq;
	endproperty
	a_inside_window: assert property (p_inside_window) else $error("jitter flag set inside window");

	property p_rbd_range;
		@(posedge sys_clk) disable iff (sys_rst)
		latency_variation_value <= `LSC_RBD_MAX;
	endproperty
	a_rbd_range: assert property (p_rbd_range) else $error("buffer delay above ten");

	property p_rbd_zero;
		@(posedge sys_clk) disable iff (sys_rst)
		(local_multiframe_clock && latency_variation_value == 4'h0 && link_enable) |=> ##0 lane_read_start || !link_enable;
	endproperty
	a_rbd_zero: assert property (p_rbd_zero) else $error("zero buffer delay did not release");

	property p_subclass_refuse;
		@(posedge sys_clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `LSC_OFF_SUBCLASS_CFG && reg_wdata[7:5] > `LSC_SUBCLASS_1) |=> subclass == $past(subclass);
	endproperty
	a_subclass_refuse: assert property (p_subclass_refuse) else $error("unsupported subclass taken");

endmodule : lsc_sync_ctrl
`default_nettype wire

/* hdl/lsc_defines.svh */
// Purpose: register offsets, field positions, reset values and counts for the lmfc sync block
// Assumes: 12-bit register addresses, 8-bit register data
// Notes:   included by bare name
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

`define LSC_OFF_STATUS_LOW      12'h034
`define LSC_OFF_STATUS_HIGH     12'h035
`define LSC_OFF_PULSE_COUNT     12'h036
`define LSC_OFF_PHASE_LOW       12'h037
`define LSC_OFF_PHASE_HIGH      12'h038
`define LSC_OFF_WINDOW_CFG      12'h039
`define LSC_OFF_MODE_CFG        12'h03a
`define LSC_OFF_IRQ_STATUS      12'h03b
`define LSC_OFF_LINK_CTRL       12'h300
`define LSC_OFF_LATENCY         12'h302
`define LSC_OFF_DELAY_CFG       12'h304
`define LSC_OFF_VARIATION_CFG   12'h306
`define LSC_OFF_SUBCLASS_CFG    12'h458

`define LSC_MODE_MONITOR        2'h0
`define LSC_MODE_CONTINUOUS     2'h1
`define LSC_MODE_ONE_SHOT       2'h2
`define LSC_WINDOW_MASK         6'h3c
`define LSC_SUBCLASS_LSB        5
`define LSC_SUBCLASS_0          3'h0
`define LSC_SUBCLASS_1          3'h1

`define LSC_RST_WINDOW          6'h04
`define LSC_RST_MODE            2'h0
`define LSC_RST_SUBCLASS        3'h1
`define LSC_RST_DELAY           8'h00
`define LSC_RST_VARIATION       4'h0

`define LSC_DIV_RATIO           4
`define LSC_RBD_MAX             4'ha
`define LSC_SC0_REPEAT_DAC      32
`define LSC_SC1_ALIGN_DAC       4

`endif

/* hdl/lsc_pkg.sv */
// Purpose: shared types of the lmfc sync block
// Assumes: nothing beyond the defines header
// Notes:   constants live in lsc_defines.svh
package lsc_pkg;

	typedef enum logic [1:0] {
		ST_MONITOR,
		ST_ARMED,
		ST_CONTINUOUS
	} lsc_sync_state_e;

	typedef logic [7:0] lsc_byte_t;

endpackage : lsc_pkg

/* hdl/lsc_rbd_delay.sv */
// Purpose: receive buffer delay, holds a start pulse back by a programmed number of pclk ticks
// Assumes: tick is a one-cycle processing clock enable
// Notes:   a zero delay fires one sys_clk after the start
`timescale 1ns/100ps
`default_nettype none
module lsc_rbd_delay #(
	parameter int DW = 4
) (
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	input  wire logic          tick,
	input  wire logic          start,
	input  wire logic [DW-1:0] delay,
	output logic               fire
);
	logic [DW-1:0] remain;
	logic          busy;

	initial begin
		if (DW < 1 || DW > 8) $error("lsc_rbd_delay: DW out of range");
	end

	// a new start restarts the wait, so one read per local multiframe period
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			remain <= '0;
			busy   <= 1'b0;
			fire   <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (start && tick) begin
				if (delay == '0) begin
					fire <= 1'b1;
					busy <= 1'b0;
				end else begin
					remain <= delay;
					busy   <= 1'b1;
				end
			end else if (busy && tick) begin
				if (remain == DW'(1)) begin
					fire <= 1'b1;
					busy <= 1'b0;
				end
				remain <= remain - DW'(1);
			end
		end
	end

endmodule : lsc_rbd_delay
`default_nettype wire

/* verif/lsc_far_end.sv */
// Purpose: far end model: sysref source and first-sample marker of the deframer
// Assumes: bench requests change on falling edges
// Notes:   acts one falling edge after a request; both lines are driven low when idle
`timescale 1ns/100ps
`default_nettype none
module lsc_far_end (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       ref_req,
	input  wire logic       data_req,
	input  wire logic [5:0] data_dly,
	output logic            sysref,
	output logic            data_start
);
	logic [2:0] ref_hold;
	logic [5:0] data_cnt;
	initial begin
		sysref     = 1'b0;
		data_start = 1'b0;
	end
	// high for four dac clocks so one div-4 sample always sees the rise
	always @(negedge sys_clk) begin
		if (sys_rst) begin
			ref_hold <= 3'h0;
			sysref   <= 1'b0;
		end else begin
			ref_hold <= ref_req ? 3'h4 : ref_hold - 3'(ref_hold != 3'h0);
			sysref   <= ref_req || ref_hold > 3'h1;
		end
	end
	// first sample data_dly dac clocks after the request, short or long
	always @(negedge sys_clk) begin
		if (sys_rst || data_req) begin
			data_cnt   <= sys_rst ? 6'h00 : data_dly;
			data_start <= 1'b0;
		end else begin
			data_cnt   <= data_cnt - 6'(data_cnt != 6'h00);
			data_start <= data_cnt == 6'h01;
		end
	end
endmodule : lsc_far_end
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for lsc_sync_ctrl
// Assumes: multiframe shortened to 16 pclk; register delay 0 until the last scenario
// Notes:   multiframe phase is the cycle count modulo the period, seen at the pulse
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int PMF = 16;
	localparam int MF  = PMF * 4;
	localparam int VAR = (3 + 1) - (1 - 1);
	localparam int DEL = (1 - 1) % PMF;
	logic        sys_clk   = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [11:0] reg_addr  = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        ref_req   = 1'b0;
	logic        data_req  = 1'b0;
	logic [5:0]  data_dly  = 6'h00;
	logic        sysref;
	logic        data_start;
	logic [7:0]  reg_rdata;
	logic        pclk_en;
	logic        lmfc;
	logic        lane_read_start;
	logic        link_enable;
	logic        irq;
	int          err_total = 0;
	int          n_checks  = 0;
	int          cyc       = 0;
	int          p0;
	int          p1;

	lsc_sync_ctrl #(.PCLKS_PER_MF(PMF)) u_lsc_sync_ctrl (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .sysref(sysref), .data_start(data_start),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pclk_en(pclk_en), .local_multiframe_clock(lmfc),
		.lane_read_start(lane_read_start), .link_enable(link_enable), .ref_phase_error_irq(irq));
	lsc_far_end u_lsc_far_end (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ref_req(ref_req), .data_req(data_req),
		.data_dly(data_dly), .sysref(sysref), .data_start(data_start));

	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic results();
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(negedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(negedge sys_clk);
		reg_rd <= 1'b0;
		chk($sformatf("reg %h", a), reg_rdata, e);
	endtask : rchk

	// ends on the falling edge just before a multiframe boundary
	task automatic wait_lmfc();
		int i;
		i = 0;
		do begin
			@(negedge sys_clk);
			i++;
		end while (lmfc !== 1'b1 && i < 2 * MF);
		chk("lmfc pulse", lmfc, 1'b1);
	endtask : wait_lmfc

	task automatic phase(output int ph);
		wait_lmfc();
		ph = cyc % MF;
	endtask : phase

	// event lands k pclk after the boundary, sampled on div-4 phase p
	task automatic send_ref(input int k, input int p);
		wait_lmfc();
		repeat (4 * k - 4 + p) @(negedge sys_clk);
		ref_req <= 1'b1;
		@(negedge sys_clk);
		ref_req <= 1'b0;
		repeat (8) @(negedge sys_clk);
	endtask : send_ref

	task automatic send_data(input int l);
		wait_lmfc();
		data_dly <= 6'(4 * l + 2);
		data_req <= 1'b1;
		@(negedge sys_clk);
		data_req <= 1'b0;
		repeat (4 * l + 8) @(negedge sys_clk);
	endtask : send_data

	task automatic t_reset();
		logic [11:0] a[8] = '{12'h039, 12'h03a, 12'h458, 12'h304, 12'h306, 12'h300, 12'h302, 12'h0ff};
		logic [7:0]  e[8] = '{8'h04, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		chk("link_enable", link_enable, 1'b0);
		chk("irq", irq, 1'b0);
		foreach (a[i]) rchk(a[i], e[i]);
	endtask : t_reset

	task automatic t_count();
		wr(12'h036, 8'ha5);
		wr(12'h034, 8'h00);
		rchk(12'h036, 8'h00);
		send_ref(2, 0);
		rchk(12'h036, 8'h00);
		wr(12'h034, 8'h5a);
		rchk(12'h036, 8'h01);
		rchk(12'h034, 8'h08);
		rchk(12'h035, 8'h00);
		wr(12'h036, 8'hff);
		wr(12'h034, 8'h00);
		rchk(12'h036, 8'h00);
	endtask : t_count

	task automatic t_thermo();
		for (int p = 0; p < 4; p++) begin
			send_ref(1, p);
			rchk(12'h037, 8'(((2 << p) - 1) << 4));
			rchk(12'h038, 8'h00);
		end
	endtask : t_thermo

	// monitor mode throughout: flags may move, the multiframe must not
	task automatic t_window();
		logic [7:0] w[4] = '{8'h04, 8'h0b, 8'h0b, 8'h07};
		int         k[4] = '{1, 2, 14, 2};
		logic       e[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		phase(p0);
		foreach (w[i]) begin
			wr(12'h039, w[i]);
			wr(12'h03b, 8'h01);
			@(negedge sys_clk);
			chk("irq clear", irq, 1'b0);
			send_ref(k[i], 0);
			chk("irq", irq, e[i]);
		end
		send_ref(1, 0);
		chk("irq sticky", irq, 1'b1);
		rchk(12'h03b, 8'h01);
		phase(p1);
		chk("monitor phase", 12'(p1), 12'(p0));
	endtask : t_window

	task automatic t_oneshot();
		wr(12'h03a, 8'h00);
		wr(12'h03a, 8'h02);
		rchk(12'h03a, 8'h02);
		phase(p0);
		send_ref(2, 0);
		phase(p1);
		chk("one-shot align", 12'(p1), 12'((p0 + 8) % MF));
		send_ref(3, 0);
		phase(p0);
		chk("after one-shot", 12'(p0), 12'(p1));
	endtask : t_oneshot

	task automatic t_cont();
		wr(12'h03a, 8'h01);
		repeat (2) begin
			phase(p0);
			send_ref(1, 0);
			phase(p1);
			chk("continuous align", 12'(p1), 12'((p0 + 4) % MF));
		end
		wr(12'h03a, 8'h03);
		phase(p0);
		send_ref(1, 0);
		phase(p1);
		chk("code 3 monitors", 12'(p1), 12'(p0));
		wr(12'h03a, 8'h00);
	endtask : t_cont

	task automatic t_sc0();
		wr(12'h458, 8'h00);
		wr(12'h458, 8'h40);
		rchk(12'h458, 8'h00);
		wr(12'h03a, 8'h01);
		repeat (3 * MF) @(negedge sys_clk);
		wr(12'h036, 8'h00);
		phase(p0);
		send_ref(2, 0);
		phase(p1);
		chk("sysref ignored", 12'(p1), 12'(p0));
		wr(12'h034, 8'h00);
		rchk(12'h036, 8'h00);
		wr(12'h03a, 8'h00);
		wr(12'h458, 8'h20);
	endtask : t_sc0

	task automatic t_latency();
		send_data(2);
		rchk(12'h302, 8'h00);
		wr(12'h300, 8'h01);
		for (int l = 1; l < 4; l++) begin
			send_data(l);
			rchk(12'h302, 8'(l));
		end
		chk("link_enable", link_enable, 1'b1);
	endtask : t_latency

	task automatic t_rbd();
		logic [7:0] w[3] = '{8'(VAR), 8'h00, 8'h0f};
		int         v[3] = '{VAR, 0, 10};
		int         first;
		int         cnt;
		int         np;
		foreach (w[i]) begin
			wr(12'h306, w[i]);
			rchk(12'h306, 8'(v[i]));
			repeat (MF) @(negedge sys_clk);
			wait_lmfc();
			first = 0;
			cnt   = 0;
			np    = 0;
			for (int j = 1; j <= MF; j++) begin
				@(negedge sys_clk);
				if (pclk_en === 1'b1) np++;
				if (lane_read_start === 1'b1) begin
					cnt++;
					if (first == 0) first = j;
				end
			end
			chk("buffer delay", 12'(first), 12'(4 * v[i] + 1));
			chk("reads per frame", 12'(cnt), 12'h001);
			chk("pclk rate", 12'(np), 12'(PMF));
		end
	endtask : t_rbd

	task automatic t_delay();
		wr(12'h304, 8'(DEL));
		phase(p0);
		wr(12'h304, 8'h03);
		repeat (MF) @(negedge sys_clk);
		phase(p1);
		chk("lmfc delay", 12'(p1), 12'((p0 + 12) % MF));
	endtask : t_delay

	initial begin
		repeat (3) @(negedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_count();
		t_thermo();
		t_window();
		t_oneshot();
		t_cont();
		t_sc0();
		t_latency();
		t_rbd();
		t_delay();
		results();
	end

	// whole run needs about 3100 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		err_total++;
		results();
	end
endmodule : testbench
`default_nettype wire
